/* hw/scp_device.sv */
`timescale 1ns/1ps
`include "scp_regs.svh"
// Notes on behaviour
// [RL1] Cycle opens with eight-edge instruction byte
// [RL2] Chip select high then low restarts
// [RL3] Aborted partial byte is never committed
// [RL4] Data bytes commit on their last bit
// [RL5] Instruction bit 7: one reads, zero writes
// [RL6] Bits 6..0 give start address
// [RL7] Sample on rising, launch on falling
// [RL8] Host keeps serial clock at most 40 MHz
// [RL9] Chip select high floats both outputs
// [RL10] Host holds chip select low throughout
// [RL11] Writes via data pin; bit7 enables return
// [RL12] Bidirectional mode keeps output pin floating
// [RL13] Bit 6 selects order, reset MSB-first
// [RL14] LSB-first mode assembles lowest bit first
// [RL15] MSB-first address decrements per byte
// [RL16] LSB-first address increments per byte
// [RL17] Host sends MSB-first bursts high-to-low
// [RL18] Every event flag has matching enable
// [RL19] Format resets 0x20, clock control 0x37
// [RL20] Flags sticky until one written; holes ignored
module scp_device
    import scp_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       srst_i,
    // Serial link
    scp_if.device           link,
    // Event pulses from the converter
    input  wire logic [7:0] event_low_i,
    input  wire logic [7:0] event_high_i,
    // Register contents toward the converter
    output logic      [7:0] port_config_o,
    output logic      [7:0] power_down_o,
    output logic      [7:0] format_o,
    output logic      [7:0] irq_en_low_o,
    output logic      [7:0] irq_en_high_o,
    output logic      [7:0] flags_low_o,
    output logic      [7:0] flags_high_o,
    output logic      [7:0] clk_ctrl_o
);

    logic       [2:0] sclk_sync_q;
    logic       [1:0] cs_sync_q;
    logic       [1:0] sdio_sync_q;
    logic             sclk_rise;
    logic             sclk_fall;
    logic             cs_act;
    logic             din;
    scp_phase_e       phase_q;
    logic       [2:0] bit_cnt_q;
    scp_byte_t        in_sh_q;
    scp_byte_t        in_nxt;
    logic       [6:0] addr_q;
    logic       [6:0] addr_step;
    logic             byte_done;
    logic             wr_en;
    logic             ld_en;
    logic       [6:0] ld_addr;
    scp_byte_t        out_sh_q;
    logic             drive_q;
    logic             sdo_q;
    logic             sdo_oe_n_q;
    logic             sdio_oe_n_q;
    scp_byte_t        cfg_q;
    scp_byte_t        pwr_q;
    scp_byte_t        fmt_q;
    scp_byte_t        ien0_q;
    scp_byte_t        ien1_q;
    scp_byte_t        flg0_q;
    scp_byte_t        flg1_q;
    scp_byte_t        clk_q;
    logic             lsb_first;
    logic             bidir;

    // Register read decode; holes read zero
    function automatic scp_byte_t rd_mux(input logic [6:0] a);
        scp_byte_t v;
        v = 8'h00;
        if (a == `SCP_A_PORT_CFG) begin
            v = cfg_q;
        end else if (a == `SCP_A_PWR_DOWN) begin
            v = pwr_q;
        end else if (a == `SCP_A_FORMAT) begin
            v = fmt_q;
        end else if (a == `SCP_A_IEN_LOW) begin
            v = ien0_q;
        end else if (a == `SCP_A_IEN_HIGH) begin
            v = ien1_q;
        end else if (a == `SCP_A_FLAG_LOW) begin
            v = flg0_q;
        end else if (a == `SCP_A_FLAG_HIGH) begin
            v = flg1_q;
        end else if (a == `SCP_A_CLK_CTRL) begin
            v = clk_q;
        end
        return v;
    endfunction : rd_mux

    // Two-stage synchronisers plus edge history for the clock
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sclk_sync_q <= 3'h0;
            cs_sync_q   <= 2'h3;
            sdio_sync_q <= 2'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], link.sclk};
            cs_sync_q   <= {cs_sync_q[0], link.cs_n};
            sdio_sync_q <= {sdio_sync_q[0], link.sdio};
        end
    end

    assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2]; // RL7
    assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2]; // RL7
    assign cs_act    = ~cs_sync_q[1];
    assign din       = sdio_sync_q[1]; // RL11
    assign lsb_first = cfg_q[`SCP_CFG_LSB]; // RL13
    assign bidir     = cfg_q[`SCP_CFG_BIDIR];

    // Byte assembly in the selected order
    assign in_nxt = lsb_first ? {din, in_sh_q[7:1]} // RL14
                              : {in_sh_q[6:0], din};
    assign addr_step = lsb_first ? addr_q + 7'h01 // RL16
                                 : addr_q - 7'h01; // RL15
    assign byte_done = cs_act & sclk_rise & (bit_cnt_q == 3'h7);
    assign wr_en     = byte_done & (phase_q == PH_WRITE); // RL4 RL3
    assign ld_en     = byte_done &
                       ((phase_q == PH_INSTR) ? in_nxt[`SCP_INS_RW]
                                              : (phase_q == PH_READ));
    assign ld_addr   = (phase_q == PH_INSTR) ? in_nxt[6:0] : addr_step;

    // Sequencer: bit count, phase and byte address
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !cs_act) begin
            phase_q   <= PH_INSTR; // RL2
            bit_cnt_q <= 3'h0; // RL3
            in_sh_q   <= 8'h00;
            addr_q    <= 7'h00;
        end else if (sclk_rise) begin
            in_sh_q   <= in_nxt;
            bit_cnt_q <= bit_cnt_q + 3'h1; // RL1
            if (bit_cnt_q == 3'h7) begin
                if (phase_q == PH_INSTR) begin
                    addr_q  <= in_nxt[6:0]; // RL6
                    phase_q <= in_nxt[`SCP_INS_RW] ? PH_READ // RL5
                                                   : PH_WRITE;
                end else begin
                    addr_q <= addr_step; // RL15 RL16
                end
            end
        end
    end

    // Read shifter: load at byte end, launch on falling edges
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !cs_act) begin
            out_sh_q <= 8'h00;
            drive_q  <= 1'b0;
            sdo_q    <= 1'b0;
        end else if (ld_en) begin
            out_sh_q <= rd_mux(ld_addr);
        end else if (sclk_fall && phase_q == PH_READ) begin
            drive_q  <= 1'b1;
            sdo_q    <= lsb_first ? out_sh_q[0] : out_sh_q[7]; // RL7
            out_sh_q <= lsb_first ? {1'b0, out_sh_q[7:1]}
                                  : {out_sh_q[6:0], 1'b0};
        end
    end

    // Output enables, floating whenever chip select is high
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sdo_oe_n_q  <= 1'b1;
            sdio_oe_n_q <= 1'b1;
        end else begin
            sdo_oe_n_q  <= ~(cs_act & drive_q & ~bidir); // RL9 RL12
            sdio_oe_n_q <= ~(cs_act & drive_q & bidir); // RL9 RL11
        end
    end

    assign link.dev_sdo_o     = sdo_q;
    assign link.dev_sdo_oe_n  = sdo_oe_n_q;
    assign link.dev_sdio_o    = sdo_q;
    assign link.dev_sdio_oe_n = sdio_oe_n_q;

    // Plain read/write registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cfg_q  <= `SCP_RST_PORT_CFG; // RL13
            pwr_q  <= `SCP_RST_PWR_DOWN;
            fmt_q  <= `SCP_RST_FORMAT; // RL19
            ien0_q <= `SCP_RST_IEN;
            ien1_q <= `SCP_RST_IEN;
            clk_q  <= `SCP_RST_CLK_CTRL; // RL19
        end else if (wr_en) begin
            if (addr_q == `SCP_A_PORT_CFG) begin
                cfg_q <= in_nxt & `SCP_M_PORT_CFG;
            end else if (addr_q == `SCP_A_PWR_DOWN) begin
                pwr_q <= in_nxt & `SCP_M_PWR_DOWN;
            end else if (addr_q == `SCP_A_FORMAT) begin
                fmt_q <= in_nxt & `SCP_M_FORMAT;
            end else if (addr_q == `SCP_A_IEN_LOW) begin
                ien0_q <= in_nxt & `SCP_M_EV_LOW; // RL18
            end else if (addr_q == `SCP_A_IEN_HIGH) begin
                ien1_q <= in_nxt & `SCP_M_EV_HIGH; // RL18
            end else if (addr_q == `SCP_A_CLK_CTRL) begin
                clk_q <= (in_nxt & `SCP_M_CLK_RW) | `SCP_CLK_FIXED; // RL19
            end
        end
    end

    // Sticky event flags; a new event beats a same-cycle clear
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            flg0_q <= 8'h00;
            flg1_q <= 8'h00;
        end else begin
            flg0_q <= (flg0_q & ~((wr_en && addr_q == `SCP_A_FLAG_LOW)
                                  ? in_nxt : 8'h00)) // RL20
                      | (event_low_i & `SCP_M_EV_LOW); // RL18
            flg1_q <= (flg1_q & ~((wr_en && addr_q == `SCP_A_FLAG_HIGH)
                                  ? in_nxt : 8'h00)) // RL20
                      | (event_high_i & `SCP_M_EV_HIGH); // RL18
        end
    end

    assign port_config_o = cfg_q;
    assign power_down_o  = pwr_q;
    assign format_o      = fmt_q;
    assign irq_en_low_o  = ien0_q;
    assign irq_en_high_o = ien1_q;
    assign flags_low_o   = flg0_q;
    assign flags_high_o  = flg1_q;
    assign clk_ctrl_o    = clk_q;

endmodule : scp_device

/* inc/scp_regs.svh */
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// Device register addresses (7-bit serial address space)
`define SCP_A_PORT_CFG   7'h00
`define SCP_A_PWR_DOWN   7'h01
`define SCP_A_FORMAT     7'h03
`define SCP_A_IEN_LOW    7'h04
`define SCP_A_IEN_HIGH   7'h05
`define SCP_A_FLAG_LOW   7'h06
`define SCP_A_FLAG_HIGH  7'h07
`define SCP_A_CLK_CTRL   7'h08

// Reset values
`define SCP_RST_PORT_CFG 8'h00
`define SCP_RST_PWR_DOWN 8'h00
`define SCP_RST_FORMAT   8'h20
`define SCP_RST_IEN      8'h00
`define SCP_RST_CLK_CTRL 8'h37

// Implemented bits of each register
`define SCP_M_PORT_CFG   8'hF0
`define SCP_M_PWR_DOWN   8'hE0
`define SCP_M_FORMAT     8'hFC
`define SCP_M_EV_LOW     8'hF7
`define SCP_M_EV_HIGH    8'h1C
`define SCP_M_CLK_RW     8'hF0
`define SCP_CLK_FIXED    8'h07

// Field positions
`define SCP_CFG_BIDIR    7
`define SCP_CFG_LSB      6
`define SCP_INS_RW       7

// Controller registers on the AHB-Lite side (byte addresses)
`define SCP_H_CTRL       8'h00
`define SCP_H_CMD        8'h04
`define SCP_H_TXDATA     8'h08
`define SCP_H_RXDATA     8'h0C
`define SCP_H_STATUS     8'h10
`define SCP_HC_LSB       0
`define SCP_HC_BIDIR     1

// Serial clock timing
`define SCP_CORE_CLK_NS  50
`define SCP_SCLK_HALF_NS 400
`define SCP_SCLK_HALF_CYC \
    ((`SCP_SCLK_HALF_NS + `SCP_CORE_CLK_NS - 1) / `SCP_CORE_CLK_NS)

`endif

/* inc/scp_pkg.sv */
package scp_pkg;

    typedef logic [7:0] scp_byte_t;

    // Device sequencer phase
    typedef enum logic [1:0] {
        PH_INSTR = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ  = 2'b10
    } scp_phase_e;

    // Controller link state
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_LOW   = 3'b001,
        HS_HIGH  = 3'b010,
        HS_TRAIL = 3'b011,
        HS_GAP   = 3'b100
    } scp_hstate_e;

endpackage : scp_pkg

/* inc/scp_if.sv */
`timescale 1ns/1ps
interface scp_if;
    logic cs_n;
    logic sclk;
    logic host_sdio_o;
    logic host_sdio_oe_n;
    logic dev_sdio_o;
    logic dev_sdio_oe_n;
    logic dev_sdo_o;
    logic dev_sdo_oe_n;
    logic sdio;
    logic serial_data_out_pin;

    // Wire levels; an undriven line floats high
    assign sdio = !host_sdio_oe_n ? host_sdio_o :
                  (!dev_sdio_oe_n ? dev_sdio_o : 1'b1);
    assign serial_data_out_pin  = !dev_sdo_oe_n ? dev_sdo_o : 1'b1;

    modport host (
        output cs_n, sclk, host_sdio_o, host_sdio_oe_n,
        input  sdio, serial_data_out_pin
    );
    modport device (
        input  cs_n, sclk, sdio,
        output dev_sdio_o, dev_sdio_oe_n, dev_sdo_o, dev_sdo_oe_n
    );
endinterface : scp_if

/* hw/scp_host.sv */
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_host
    import scp_pkg::*;
#(
    parameter int unsigned HALF_CYC = `SCP_SCLK_HALF_CYC
)(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Serial link
    scp_if.host              link
);

    // Read data must return before the next sample point
    if (HALF_CYC < 7 || HALF_CYC > 256) begin : g_bad_half // RL8
        $error("HALF_CYC must lie in 7..256");
    end

    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

    scp_hstate_e  st_q;
    logic         ap_wr_q;
    logic [7:0]   ap_addr_q;
    logic [31:0]  hrdata_q;
    logic [1:0]   ctrl_q;
    logic [31:0]  tx_q;
    logic [31:0]  rx_q;
    logic         start;
    logic [1:0]   sdi_sync_q;
    logic [7:0]   cnt_q;
    logic [2:0]   bit_q;
    logic [2:0]   byte_q;
    logic [1:0]   nb_q;
    logic         rw_q;
    scp_byte_t    sh_q;
    scp_byte_t    sh_nxt;
    scp_byte_t    rx_sh_q;
    scp_byte_t    rx_nxt;
    logic [31:0]  txb_q;
    logic         cs_n_q;
    logic         sclk_q;
    logic         sdio_q;
    logic         oe_n_q;
    logic         lsb;

    assign lsb = ctrl_q[`SCP_HC_LSB];

    // Address phase capture and registered read data
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ap_wr_q   <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            ap_wr_q   <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
            ap_addr_q <= haddr_i[7:0];
            if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
                if (haddr_i[7:0] == `SCP_H_CTRL) begin
                    hrdata_q <= {30'h0, ctrl_q};
                end else if (haddr_i[7:0] == `SCP_H_TXDATA) begin
                    hrdata_q <= tx_q;
                end else if (haddr_i[7:0] == `SCP_H_RXDATA) begin
                    hrdata_q <= rx_q;
                end else if (haddr_i[7:0] == `SCP_H_STATUS) begin
                    hrdata_q <= {31'h0, st_q != HS_IDLE};
                end else begin
                    hrdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    assign hrdata_o    = hrdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // Software-written settings
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ctrl_q <= 2'h0;
            tx_q   <= 32'h0000_0000;
        end else if (ap_wr_q && ap_addr_q == `SCP_H_CTRL) begin
            ctrl_q <= hwdata_i[1:0];
        end else if (ap_wr_q && ap_addr_q == `SCP_H_TXDATA) begin
            tx_q <= hwdata_i;
        end
    end

    assign start = ap_wr_q & (ap_addr_q == `SCP_H_CMD) & (st_q == HS_IDLE);

    // Returned data, from the pin selected by the wiring mode
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sdi_sync_q <= 2'h0;
        end else begin
            sdi_sync_q <= {sdi_sync_q[0], ctrl_q[`SCP_HC_BIDIR]
                                          ? link.sdio : link.serial_data_out_pin};
        end
    end

    assign sh_nxt = lsb ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};
    assign rx_nxt = lsb ? {sdi_sync_q[1], rx_sh_q[7:1]}
                        : {rx_sh_q[6:0], sdi_sync_q[1]};

    // Link sequencer: divided clock, shifting and sampling
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_q    <= HS_IDLE;
            cnt_q   <= 8'h00;
            bit_q   <= 3'h0;
            byte_q  <= 3'h0;
            nb_q    <= 2'h0;
            rw_q    <= 1'b0;
            sh_q    <= 8'h00;
            rx_sh_q <= 8'h00;
            rx_q    <= 32'h0000_0000;
            txb_q   <= 32'h0000_0000;
            cs_n_q  <= 1'b1;
            sclk_q  <= 1'b0;
            sdio_q  <= 1'b0;
            oe_n_q  <= 1'b1;
        end else begin
            cnt_q <= (st_q == HS_IDLE || cnt_q == HALF_M1) ? 8'h00
                                                          : cnt_q + 8'h01;
            case (st_q)
                HS_IDLE: begin
                    if (start) begin
                        st_q   <= HS_LOW;
                        cs_n_q <= 1'b0; // RL10
                        bit_q  <= 3'h0;
                        byte_q <= 3'h0;
                        nb_q   <= hwdata_i[9:8];
                        rw_q   <= hwdata_i[7]; // RL5
                        sh_q   <= hwdata_i[7:0]; // RL1 RL6
                        txb_q  <= tx_q;
                        sdio_q <= lsb ? hwdata_i[0] : hwdata_i[7];
                        oe_n_q <= 1'b0;
                    end
                end
                HS_LOW: begin
                    if (cnt_q == HALF_M1) begin
                        st_q    <= HS_HIGH;
                        sclk_q  <= 1'b1;
                        rx_sh_q <= rx_nxt; // RL7
                        if (bit_q == 3'h7 && byte_q != 3'h0) begin
                            rx_q[8 * 2'(byte_q - 3'h1) +: 8] <= rx_nxt;
                        end
                    end
                end
                HS_HIGH: begin
                    if (cnt_q == HALF_M1) begin
                        sclk_q <= 1'b0;
                        bit_q  <= bit_q + 3'h1;
                        if (bit_q != 3'h7) begin
                            st_q   <= HS_LOW;
                            sh_q   <= sh_nxt;
                            sdio_q <= lsb ? sh_nxt[0] : sh_nxt[7]; // RL14
                        end else if (byte_q == 3'({1'b0, nb_q} + 3'h1)) begin
                            st_q   <= HS_TRAIL;
                            oe_n_q <= 1'b1;
                        end else begin
                            st_q   <= HS_LOW;
                            byte_q <= byte_q + 3'h1;
                            sh_q   <= txb_q[7:0];
                            txb_q  <= {8'h00, txb_q[31:8]};
                            sdio_q <= lsb ? txb_q[0] : txb_q[7];
                            oe_n_q <= rw_q;
                        end
                    end
                end
                HS_TRAIL: begin
                    if (cnt_q == HALF_M1) begin
                        st_q   <= HS_GAP;
                        cs_n_q <= 1'b1;
                    end
                end
                HS_GAP: begin
                    if (cnt_q == HALF_M1) begin
                        st_q <= HS_IDLE;
                    end
                end
                default: begin
                    st_q <= HS_IDLE;
                end
            endcase
        end
    end

    assign link.cs_n           = cs_n_q;
    assign link.sclk           = sclk_q;
    assign link.host_sdio_o    = sdio_q;
    assign link.host_sdio_oe_n = oe_n_q;

endmodule : scp_host

/* testbench/scp_asserts.sv */
`timescale 1ns/1ps
module scp_asserts
    import scp_pkg::*;
#(
    parameter int unsigned HALF_CYC = 8
)(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Link signals
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic host_sdio_o,
    input wire logic host_sdio_oe_n,
    input wire logic dev_sdio_o,
    input wire logic dev_sdio_oe_n,
    input wire logic dev_sdo_o,
    input wire logic dev_sdo_oe_n
);
    logic [8:0] run_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    // Cycles since the serial clock last moved, saturating
    always_ff @(posedge core_clk_i) begin
        if (srst_i || $changed(sclk)) begin
            run_q <= 9'h000;
        end else if (run_q != 9'h1FF) begin
            run_q <= run_q + 9'h001;
        end
    end

    chk_float_idle: assert property (
        cs_n [*4] |-> dev_sdio_oe_n && dev_sdo_oe_n)
        else $error("device drives while deselected");
    chk_one_output: assert property (
        dev_sdio_oe_n || dev_sdo_oe_n)
        else $error("device drives both data pins");
    chk_sclk_still: assert property (
        cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    chk_half_period: assert property (
        $changed(sclk) |-> run_q >= HALF_CYC - 1)
        else $error("serial clock phase too short");
    chk_dev_quiet: assert property (
        $fell(cs_n) |-> (dev_sdio_oe_n && dev_sdo_oe_n) [*8])
        else $error("device drives during instruction");
    chk_host_drives: assert property (
        $fell(cs_n) |-> !host_sdio_oe_n)
        else $error("host not driving at frame start");
    chk_no_contend: assert property (
        !dev_sdio_oe_n |-> host_sdio_oe_n)
        else $error("both ends drive the data pin");
    chk_cs_gap: assert property (
        $rose(cs_n) |-> cs_n [*3])
        else $error("chip select gap too short");
    chk_sdo_launch: assert property (
        sclk && $past(sclk) && !dev_sdo_oe_n |-> $stable(dev_sdo_o))
        else $error("output pin moved while clock high");
    chk_sdio_launch: assert property (
        sclk && $past(sclk) && !dev_sdio_oe_n |-> $stable(dev_sdio_o))
        else $error("device data moved while clock high");
    chk_host_launch: assert property (
        sclk && $past(sclk) && !host_sdio_oe_n |-> $stable(host_sdio_o))
        else $error("host data moved while clock high");

    // Main scenarios reached
    cov_frame: cover property ($fell(cs_n));
    cov_sdo_read: cover property (!dev_sdo_oe_n);
    cov_sdio_read: cover property (!dev_sdio_oe_n);
endmodule : scp_asserts

/* testbench/serial_config_port_tb.sv */
`timescale 1ns/1ps
`include "scp_regs.svh"
module serial_config_port_tb
    import scp_pkg::*;
;
    logic        clk, srst, kill, hrst, hsel, hwrite, hrdy, hresp, rd_dp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd_val, d;
    logic [7:0]  ev_lo, ev_hi, cfg, pwr, fmt, ien_lo, ien_hi;
    logic [7:0]  fl_lo, fl_hi, clkc;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    int          mismatches, checks, seed;

    assign hrst = srst || kill;
    scp_if i_scp_if();
    scp_host #(.HALF_CYC(8)) i_scp_host (
        .core_clk_i(clk), .srst_i(hrst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .link(i_scp_if.host));
    scp_device i_scp_device (
        .core_clk_i(clk), .srst_i(srst), .link(i_scp_if.device),
        .event_low_i(ev_lo), .event_high_i(ev_hi),
        .port_config_o(cfg), .power_down_o(pwr), .format_o(fmt),
        .irq_en_low_o(ien_lo), .irq_en_high_o(ien_hi),
        .flags_low_o(fl_lo), .flags_high_o(fl_hi), .clk_ctrl_o(clkc));
    scp_asserts #(.HALF_CYC(8)) i_scp_asserts (
        .core_clk_i(clk), .srst_i(hrst), .cs_n(i_scp_if.cs_n),
        .sclk(i_scp_if.sclk), .host_sdio_o(i_scp_if.host_sdio_o),
        .host_sdio_oe_n(i_scp_if.host_sdio_oe_n),
        .dev_sdio_o(i_scp_if.dev_sdio_o),
        .dev_sdio_oe_n(i_scp_if.dev_sdio_oe_n),
        .dev_sdo_o(i_scp_if.dev_sdo_o),
        .dev_sdo_oe_n(i_scp_if.dev_sdo_oe_n));

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // One single AHB transfer, waits on hready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        rd_val = hrdata;
    endtask : ahb

    // Read with expected value and compare mask noted first
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
        exp_q.push_back({m, v});
        ahb(1'b0, a, 32'h0);
    endtask : rd

    // Start one serial cycle and poll until it is over
    task automatic frame(input logic r, input logic [6:0] a,
                         input logic [1:0] n, input logic [31:0] tx);
        logic seen;
        seen = 1'b0;
        ahb(1'b1, `SCP_H_TXDATA, tx);
        ahb(1'b1, `SCP_H_CMD, {22'h0, n, r, a});
        for (int k = 0; k < 3000; k++) begin
            rd(`SCP_H_STATUS, 32'h0, 32'h0);
            if (rd_val[0] === 1'b1) seen = 1'b1;
            if (seen && rd_val[0] === 1'b0) return;
        end
        mismatches++;
        tally_and_finish();
    endtask : frame

    // Read data monitor: compares against the oldest note
    always @(posedge clk) begin
        if (rd_dp && hrdy) begin
            e = exp_q.pop_front();
            if (e[63:32] != 32'h0) chk(hrdata & e[63:32], e[31:0]);
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hrdy;
    end

    // Watchdog
    initial begin
        #(50 * 60000);
        mismatches++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        seed = 65;
        srst = 1'b1;
        {kill, hsel, hwrite} = 3'h0;
        htrans = 2'h0;
        {haddr, hwdata} = 64'h0;
        {ev_lo, ev_hi} = 16'h0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(fmt, 32'h20);
        chk(clkc, 32'h37);
        chk(cfg, 32'h00);
        // Reset values over the link, address counting down
        frame(1'b1, 7'h08, 2'h3, 32'h0);
        rd(`SCP_H_RXDATA, 32'hFFFFFFFF, 32'h00000037);
        // Random three-byte burst, highest address first
        d = $random(seed);
        frame(1'b0, 7'h05, 2'h2, d);
        chk(ien_hi, d[7:0] & `SCP_M_EV_HIGH);
        chk(ien_lo, d[15:8] & `SCP_M_EV_LOW);
        chk(fmt, d[23:16] & `SCP_M_FORMAT);
        // Sticky events, then write-one clear
        ev_lo <= 8'hFF;
        ev_hi <= 8'hFF;
        @(posedge clk);
        {ev_lo, ev_hi} <= 16'h0;
        repeat (2) @(posedge clk);
        chk(fl_lo, `SCP_M_EV_LOW);
        chk(fl_hi, `SCP_M_EV_HIGH);
        frame(1'b0, 7'h06, 2'h0, 32'h10);
        chk(fl_lo, 32'hE7);
        frame(1'b1, 7'h07, 2'h1, 32'h0);
        rd(`SCP_H_RXDATA, 32'hFFFF, 32'hE71C);
        // Hole in the map and an unmapped host word
        frame(1'b0, 7'h02, 2'h0, 32'hFF);
        frame(1'b1, 7'h02, 2'h1, 32'h0);
        rd(`SCP_H_RXDATA, 32'hFFFF, 32'h0);
        rd(8'h20, 32'hFFFFFFFF, 32'h0);
        // Cut a data byte short by resetting the host
        ahb(1'b1, `SCP_H_TXDATA, 32'hE0);
        ahb(1'b1, `SCP_H_CMD, {22'h0, 2'h0, 1'b0, 7'h01});
        repeat (200) @(posedge clk);
        kill <= 1'b1;
        repeat (2) @(posedge clk);
        kill <= 1'b0;
        repeat (4) @(posedge clk);
        chk(pwr, 32'h00);
        frame(1'b0, 7'h01, 2'h0, 32'hE0);
        chk(pwr, 32'hE0);
        // Least significant first, address counting up
        frame(1'b0, 7'h00, 2'h0, 32'h40);
        chk(cfg, 32'h40);
        ahb(1'b1, `SCP_H_CTRL, 32'h1);
        d = $random(seed);
        frame(1'b0, 7'h03, 2'h1, d);
        chk(fmt, d[7:0] & `SCP_M_FORMAT);
        chk(ien_lo, d[15:8] & `SCP_M_EV_LOW);
        frame(1'b1, 7'h06, 2'h1, 32'h0);
        rd(`SCP_H_RXDATA, 32'hFFFF, 32'h1CE7);
        // Single data pin carries read data
        frame(1'b0, 7'h00, 2'h0, 32'hC0);
        chk(cfg, 32'hC0);
        ahb(1'b1, `SCP_H_CTRL, 32'h3);
        frame(1'b1, 7'h03, 2'h0, 32'h0);
        rd(`SCP_H_RXDATA, 32'hFF, {24'h0, d[7:0] & `SCP_M_FORMAT});
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule : serial_config_port_tb
